// >>> common/ramp_pkg.sv
package ramp_pkg;
    // input ranges
    localparam int VEL_MAX        = 2047;
    localparam int ACC_MAX        = 2047;
    localparam int RATE_SHIFT_MAX = 13;
    localparam int RAMP_SHIFT_MAX = 13;
    localparam int USTEP_RES_MAX  = 8;
    // 2048 * 32 = 2^16 fixed rate divisor
    localparam int VEL_BASE_SHIFT = 16;
    // acceleration exponent 29 minus the 16 of the velocity scale
    localparam int RAMP_EXP       = 29;
    localparam int RAMP_BASE_SHIFT = RAMP_EXP - VEL_BASE_SHIFT;
    localparam int LIMIT_UPPER_OFS = 12;
    // reference rate of the scaling formulas against the system clock
    localparam int REF_MHZ        = 16;
    localparam int CLK_MHZ        = 25;
    localparam int TICK_W         = 6;
    // accumulator widths hold the largest threshold plus one bit
    localparam int STEP_ACC_W     = VEL_BASE_SHIFT + RATE_SHIFT_MAX + 2;
    localparam int RAMP_ACC_W     = RAMP_BASE_SHIFT + RAMP_SHIFT_MAX + 2;
    localparam int POS_W          = 32;
    localparam int USTEP_CNT_W    = 8;
    typedef enum logic [1:0] {
        MODE_VELOCITY    = 2'b01,
        MODE_POSITIONING = 2'b10
    } move_mode_e;
endpackage

// >>> common/accum_if.sv
`timescale 1ns/1ns
interface accum_if #(parameter int W = 31);
    logic         tick;
    logic [W-1:0] addend;
    logic [4:0]   shift;
    logic         ovf;
    modport owner (output tick, output addend, output shift, input ovf);
    modport unit  (input tick, input addend, input shift, output ovf);
endinterface

// >>> rtl/rate_accum.sv
`timescale 1ns/1ns
module rate_accum #(
    parameter int W = 31
) (
    // clock and reset
    input  wire logic clk_sys_i,
    input  wire logic sys_rst_i,
    // accumulator port
    accum_if.unit     acc
);
    logic [W-1:0] acc_reg;
    logic         ovf_reg;
    logic [W:0]   sum;
    logic [W:0]   thr;

    always_comb begin
        sum = {1'b0, acc_reg} + {1'b0, acc.addend};
        thr = {{W{1'b0}}, 1'b1} << acc.shift;
    end

    // remainder carried over so the average rate is exact
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            acc_reg <= '0;
            ovf_reg <= 1'b0;
        end else begin
            ovf_reg <= 1'b0;
            if (acc.tick) begin
                if (sum >= thr) begin
                    // excess left by a lowered shift is dropped, not paid out in bursts
                    acc_reg <= W'((sum - thr) & (thr - (W+1)'(1)));
                    ovf_reg <= 1'b1;
                end else begin
                    acc_reg <= W'(sum);
                end
            end
        end
    end

    assign acc.ovf = ovf_reg;
endmodule

// >>> rtl/step_rate_ramp_scaler.sv
`timescale 1ns/1ns
// How it works
// - pulse rate is 16 MHz times velocity over 2048, 32 and 2^rate shift.
// - velocity magnitude held within 0..2047; signed input -2047..2047 accepted.
// - rate shift 0..13 divides the pulse rate by two to that power.
// - resolution 0..8 gives 2^res microsteps per full step pulse.
// - ramp slope is 16 MHz squared times accel over 2^(ramp+rate+29).
// - acceleration is an unsigned word 0..2047.
// - positioning moves limit accel to 2^(e-1)..2^(e+12)-1, e=ramp-rate.
// - upper acceleration limit above 2047 is clamped to 2047.
// - reversal inverts motor and encoder direction, internal ramp mode only.
module step_rate_ramp_scaler (
    // clock and reset
    input  wire logic                         clk_sys_i,
    input  wire logic                         sys_rst_i,
    // motion settings
    input  wire logic signed [11:0]           vel_target_i,
    input  wire logic [10:0]                  accel_i,
    input  wire logic [3:0]                   rate_shift_i,
    input  wire logic [3:0]                   ramp_shift_i,
    input  wire logic [3:0]                   ustep_res_i,
    input  wire logic                         positioning_move_i,
    input  wire logic                         reverse_shaft_i,
    input  wire logic                         ext_step_mode_i,
    // external step/direction pins
    input  wire logic                         ext_step_i,
    input  wire logic                         ext_dir_i,
    // encoder count pulses
    input  wire logic                         enc_step_i,
    input  wire logic                         enc_dir_i,
    // driver side
    output logic                              step_o,
    output logic                              dir_o,
    output logic                              fullstep_o,
    // status
    output logic signed [11:0]                vel_now_o,
    output logic [10:0]                       accel_eff_o,
    output logic [10:0]                       accel_lo_o,
    output logic [10:0]                       accel_hi_o,
    output logic [ramp_pkg::POS_W-1:0]        ustep_pos_o,
    output logic [ramp_pkg::POS_W-1:0]        enc_pos_o
);
    accum_if #(.W(ramp_pkg::STEP_ACC_W)) step_acc ();
    accum_if #(.W(ramp_pkg::RAMP_ACC_W)) ramp_acc ();

    rate_accum #(.W(ramp_pkg::STEP_ACC_W)) u_step_acc (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .acc       (step_acc)
    );
    rate_accum #(.W(ramp_pkg::RAMP_ACC_W)) u_ramp_acc (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .acc       (ramp_acc)
    );

    logic [ramp_pkg::TICK_W-1:0]    frac_reg;
    logic                           tick_reg;
    logic signed [11:0]             vel_tgt;
    logic signed [11:0]             vel_reg;
    logic [10:0]                    vel_mag;
    logic [3:0]                     rate_sh;
    logic [3:0]                     ramp_sh;
    logic [3:0]                     res_c;
    logic [10:0]                    acc_lo;
    logic [10:0]                    acc_hi;
    logic [10:0]                    acc_eff;
    logic [10:0]                    acc_eff_reg;
    logic [10:0]                    acc_lo_reg;
    logic [10:0]                    acc_hi_reg;
    int                             lim_exp;
    ramp_pkg::move_mode_e           mode;
    logic [2:0]                     ext_step_sync;
    logic [2:0]                     ext_dir_sync;
    logic                           ext_step_st;
    logic                           ext_dir_st;
    logic                           ext_step_prev;
    logic                           pulse;
    logic                           pulse_neg;
    logic                           rev_eff;
    logic [ramp_pkg::USTEP_CNT_W:0] res_mask;
    logic [ramp_pkg::USTEP_CNT_W-1:0] ustep_cnt_reg;
    logic                           step_reg;
    logic                           dir_reg;
    logic                           full_reg;
    logic [ramp_pkg::POS_W-1:0]     pos_reg;
    logic [ramp_pkg::POS_W-1:0]     enc_reg;

    // 16 MHz reference as a fractional enable on the 25 MHz clock
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            frac_reg <= '0;
            tick_reg <= 1'b0;
        end else if (frac_reg + ramp_pkg::TICK_W'(ramp_pkg::REF_MHZ)
                     >= ramp_pkg::TICK_W'(ramp_pkg::CLK_MHZ)) begin
            frac_reg <= frac_reg + ramp_pkg::TICK_W'(ramp_pkg::REF_MHZ)
                        - ramp_pkg::TICK_W'(ramp_pkg::CLK_MHZ);
            tick_reg <= 1'b1;
        end else begin
            frac_reg <= frac_reg + ramp_pkg::TICK_W'(ramp_pkg::REF_MHZ);
            tick_reg <= 1'b0;
        end
    end

    always_comb begin
        vel_tgt = (vel_target_i < -12'sd2047) ? -12'sd2047 : vel_target_i;
        vel_mag = vel_reg[11] ? 11'(-vel_reg) : vel_reg[10:0];
        rate_sh = (rate_shift_i > 4'(ramp_pkg::RATE_SHIFT_MAX)) ?
                  4'(ramp_pkg::RATE_SHIFT_MAX) : rate_shift_i;
        ramp_sh = (ramp_shift_i > 4'(ramp_pkg::RAMP_SHIFT_MAX)) ?
                  4'(ramp_pkg::RAMP_SHIFT_MAX) : ramp_shift_i;
        res_c   = (ustep_res_i > 4'(ramp_pkg::USTEP_RES_MAX)) ?
                  4'(ramp_pkg::USTEP_RES_MAX) : ustep_res_i;
        res_mask = (9'h001 << res_c) - 9'h001;
        lim_exp = int'(ramp_sh) - int'(rate_sh);
        if (lim_exp - 1 >= 11) begin
            acc_lo = 11'(ramp_pkg::ACC_MAX);
        end else if (lim_exp >= 1) begin
            acc_lo = 11'(1 << (lim_exp - 1));
        end else begin
            acc_lo = 11'h000;
        end
        if (lim_exp + ramp_pkg::LIMIT_UPPER_OFS >= 11) begin
            acc_hi = 11'(ramp_pkg::ACC_MAX);
        end else if (lim_exp + ramp_pkg::LIMIT_UPPER_OFS >= 0) begin
            acc_hi = 11'((1 << (lim_exp + ramp_pkg::LIMIT_UPPER_OFS)) - 1);
        end else begin
            acc_hi = 11'h000;
        end
        mode = positioning_move_i ? ramp_pkg::MODE_POSITIONING : ramp_pkg::MODE_VELOCITY;
        // unsigned 11-bit word used as given in velocity mode
        unique case (mode)
            ramp_pkg::MODE_VELOCITY: begin
                acc_eff = accel_i;
            end
            ramp_pkg::MODE_POSITIONING: begin
                acc_eff = (accel_i < acc_lo) ? acc_lo :
                          (accel_i > acc_hi) ? acc_hi : accel_i;
            end
        endcase
        // reversal ignored in external step mode
        rev_eff = reverse_shaft_i & ~ext_step_mode_i;
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            acc_eff_reg <= '0;
            acc_lo_reg  <= '0;
            acc_hi_reg  <= '0;
        end else begin
            acc_eff_reg <= acc_eff;
            acc_lo_reg  <= acc_lo;
            acc_hi_reg  <= acc_hi;
        end
    end

    // slope accumulator overflows at 2^(ramp+13) per 16 MHz tick
    assign ramp_acc.tick   = tick_reg & ~ext_step_mode_i;
    assign ramp_acc.addend = ramp_pkg::RAMP_ACC_W'(acc_eff_reg);
    assign ramp_acc.shift  = 5'(ramp_pkg::RAMP_BASE_SHIFT) + 5'(ramp_sh);
    // rate accumulator overflows at 2^(16+rate shift)
    assign step_acc.tick   = tick_reg & ~ext_step_mode_i & (vel_reg != 12'sh000);
    assign step_acc.addend = ramp_pkg::STEP_ACC_W'(vel_mag);
    assign step_acc.shift  = 5'(ramp_pkg::VEL_BASE_SHIFT) + 5'(rate_sh);

    // one velocity unit per slope overflow, toward the target
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            vel_reg <= '0;
        end else if (ramp_acc.ovf) begin
            if (vel_reg < vel_tgt) begin
                vel_reg <= vel_reg + 12'sh001;
            end else if (vel_reg > vel_tgt) begin
                vel_reg <= vel_reg - 12'sh001;
            end
        end
    end

    // pins settle once the last two stages agree
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ext_step_sync <= '0;
            ext_dir_sync  <= '0;
            ext_step_st   <= 1'b0;
            ext_dir_st    <= 1'b0;
            ext_step_prev <= 1'b0;
        end else begin
            ext_step_sync <= {ext_step_sync[1:0], ext_step_i};
            ext_dir_sync  <= {ext_dir_sync[1:0], ext_dir_i};
            if (ext_step_sync[1] == ext_step_sync[2]) begin
                ext_step_st <= ext_step_sync[2];
            end
            if (ext_dir_sync[1] == ext_dir_sync[2]) begin
                ext_dir_st <= ext_dir_sync[2];
            end
            ext_step_prev <= ext_step_st;
        end
    end

    always_comb begin
        pulse     = ext_step_mode_i ? (ext_step_st & ~ext_step_prev) : step_acc.ovf;
        pulse_neg = ext_step_mode_i ? ext_dir_st : vel_reg[11];
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            step_reg      <= 1'b0;
            dir_reg       <= 1'b0;
            pos_reg       <= '0;
            ustep_cnt_reg <= '0;
            full_reg      <= 1'b0;
        end else begin
            step_reg <= pulse;
            dir_reg  <= pulse_neg ^ rev_eff;
            full_reg <= 1'b0;
            if (pulse) begin
                pos_reg       <= pulse_neg ? pos_reg - 32'h1 : pos_reg + 32'h1;
                ustep_cnt_reg <= ustep_cnt_reg + 8'h01;
                full_reg <= (ustep_cnt_reg & res_mask[7:0]) == res_mask[7:0];
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            enc_reg <= '0;
        end else if (enc_step_i) begin
            enc_reg <= (enc_dir_i ^ rev_eff) ? enc_reg - 32'h1 : enc_reg + 32'h1;
        end
    end

    assign step_o      = step_reg;
    assign dir_o       = dir_reg;
    assign fullstep_o  = full_reg;
    assign vel_now_o   = vel_reg;
    assign accel_eff_o = acc_eff_reg;
    assign accel_lo_o  = acc_lo_reg;
    assign accel_hi_o  = acc_hi_reg;
    assign ustep_pos_o = pos_reg;
    assign enc_pos_o   = enc_reg;
endmodule

// >>> verification/step_rate_ramp_scaler_chk.sv
`timescale 1ns/1ns
module step_rate_ramp_scaler_chk (
    // watched pins
    input wire logic                        clk_sys_i, sys_rst_i, positioning_move_i,
    input wire logic                        reverse_shaft_i, ext_step_mode_i, enc_step_i,
    input wire logic                        enc_dir_i, step_o, fullstep_o,
    input wire logic [3:0]                  rate_shift_i, ramp_shift_i,
    input wire logic [10:0]                 accel_i, accel_eff_o, accel_lo_o, accel_hi_o,
    input wire logic signed [11:0]          vel_now_o,
    input wire logic [ramp_pkg::POS_W-1:0]  ustep_pos_o, enc_pos_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    function automatic int e_f(logic [3:0] rp, logic [3:0] rt);
        return int'(rp > 13 ? 4'hd : rp) - int'(rt > 13 ? 4'hd : rt);
    endfunction
    lo_limit_a:
        assert property (1 |=> accel_lo_o == ((e_f($past(ramp_shift_i), $past(rate_shift_i)) < 1)
            ? 11'h0 : (e_f($past(ramp_shift_i), $past(rate_shift_i)) > 11) ? 11'h7ff
            : 11'(1 << (e_f($past(ramp_shift_i), $past(rate_shift_i)) - 1))))
        else $error("accel lower limit wrong");
    hi_clamp_a:
        assert property (1 |=> accel_hi_o
            == ((e_f($past(ramp_shift_i), $past(rate_shift_i)) < -12) ? 11'h0
            : (e_f($past(ramp_shift_i), $past(rate_shift_i)) > -2) ? 11'h7ff
            : 11'((1 << (e_f($past(ramp_shift_i), $past(rate_shift_i)) + 12)) - 1)))
        else $error("accel upper limit wrong");
    vel_accel_a:
        assert property (!positioning_move_i |=> accel_eff_o == $past(accel_i))
        else $error("velocity mode accel altered");
    pos_window_a:
        assert property (positioning_move_i |=> accel_eff_o >= accel_lo_o
            && accel_eff_o <= accel_hi_o)
        else $error("positioning accel outside window");
    step_pulse_a:
        assert property (step_o |=> !step_o) else $error("step pulse too long");
    full_step_a:
        assert property (fullstep_o |-> step_o) else $error("full step without step");
    pos_count_a:
        assert property (!step_o |-> $stable(ustep_pos_o)) else $error("position moved alone");
    enc_count_a:
        assert property (enc_step_i && !ext_step_mode_i |=> enc_pos_o == $past(enc_pos_o)
            + (($past(enc_dir_i) ^ $past(reverse_shaft_i)) ? 32'hffffffff : 32'h1))
        else $error("encoder count wrong");
    frozen_ext_a:
        assert property (ext_step_mode_i [*3] |-> $stable(vel_now_o))
        else $error("ramp moved in external mode");
    cover property (step_o);
    cover property (fullstep_o);
    cover property (positioning_move_i && accel_lo_o != 11'h0);
endmodule

// >>> verification/step_motor_model.sv
`timescale 1ns/1ns
module step_motor_model (
    // driver pins
    input  wire logic clk_sys_i,
    input  wire logic step_i,
    input  wire logic dir_i,
    input  wire logic full_i,
    // motion record
    output int        steps_o,
    output int        fulls_o,
    output logic      last_dir_o
);
    initial begin
        steps_o = 0;
        fulls_o = 0;
        last_dir_o = 1'b0;
    end
    always @(posedge clk_sys_i) begin
        if (step_i === 1'b1) begin
            steps_o <= steps_o + 1;
            last_dir_o <= dir_i;
        end
        if (full_i === 1'b1) fulls_o <= fulls_o + 1;
    end
endmodule

// >>> verification/step_rate_ramp_scaler_tb.sv
`timescale 1ns/1ns
`define CHK(n, e, s) begin checked++; if ((e) !== (s)) begin miscompares++; \
    $display("wrong value %s exp %h got %h", n, e, s); end end
module step_rate_ramp_scaler_tb;
    typedef struct {int sel; logic [31:0] v;} note_s;
    logic clk_sys_i = 0, sys_rst_i = 1, positioning_move_i = 0, reverse_shaft_i = 0;
    logic ext_step_mode_i = 0, ext_step_i = 0, ext_dir_i = 0, enc_step_i = 0, enc_dir_i = 0;
    logic signed [11:0] vel_target_i = 0, vel_now_o;
    logic [10:0] accel_i = 0, accel_eff_o, accel_lo_o, accel_hi_o;
    logic [3:0] rate_shift_i = 0, ramp_shift_i = 0, ustep_res_i = 0;
    logic step_o, dir_o, fullstep_o, last_dir;
    logic [31:0] ustep_pos_o, enc_pos_o, enc_exp = 0, p0, p1;
    int miscompares = 0, checked = 0, steps, fulls, s0, f0, n, e, lo, hi, m;
    note_s q[$], t;
    event note_ev;
    step_rate_ramp_scaler step_rate_ramp_scaler_i (.*);
    step_motor_model step_motor_model_i (.clk_sys_i(clk_sys_i), .step_i(step_o),
        .dir_i(dir_o), .full_i(fullstep_o), .steps_o(steps), .fulls_o(fulls),
        .last_dir_o(last_dir));
    initial forever #20 clk_sys_i = ~clk_sys_i;
    // settings land one edge later, so look after the second
    initial forever begin
        @(note_ev);
        repeat (2) @(posedge clk_sys_i);
        #1;
        while (q.size() > 0) begin
            t = q.pop_front();
            case (t.sel)
                0: `CHK("accel_lo", t.v[10:0], accel_lo_o)
                1: `CHK("accel_hi", t.v[10:0], accel_hi_o)
                2: `CHK("accel_eff", t.v[10:0], accel_eff_o)
                default: `CHK("enc_pos", t.v, enc_pos_o)
            endcase
        end
    end
    task automatic accel_case(logic pm, logic [3:0] rt, logic [3:0] rp, logic [10:0] a);
        @(negedge clk_sys_i);
        positioning_move_i = pm;
        rate_shift_i = rt;
        ramp_shift_i = rp;
        accel_i = a;
        e = int'(rp > 13 ? 4'hd : rp) - int'(rt > 13 ? 4'hd : rt);
        lo = e < 1 ? 0 : (e > 11 ? 2047 : 1 << (e - 1));
        hi = e < -12 ? 0 : (e > -2 ? 2047 : (1 << (e + 12)) - 1);
        q.push_back('{0, lo});
        q.push_back('{1, hi});
        q.push_back('{2, !pm ? a : (a < lo ? lo : (a > hi ? hi : a))});
        ->note_ev;
        repeat (3) @(negedge clk_sys_i);
    endtask
    task automatic enc_pulse(logic d, logic r);
        @(negedge clk_sys_i);
        enc_step_i = 1;
        enc_dir_i = d;
        reverse_shaft_i = r;
        enc_exp = (d ^ r) ? enc_exp - 1 : enc_exp + 1;
        q.push_back('{3, enc_exp});
        ->note_ev;
        @(negedge clk_sys_i);
        enc_step_i = 0;
        repeat (2) @(negedge clk_sys_i);
    endtask
    // pulse count over 10000 cycles: 6400 ticks times 2047 over 2^(16+rate)
    task automatic rate_win(logic [3:0] rt);
        rate_shift_i = rt;
        repeat (50) @(negedge clk_sys_i);
        p0 = ustep_pos_o;
        // the model counts a pulse one edge after the position moves
        @(posedge clk_sys_i);
        #1;
        s0 = steps;
        f0 = fulls;
        repeat (10000) @(negedge clk_sys_i);
        p1 = ustep_pos_o;
        @(posedge clk_sys_i);
        #1;
        n = steps - s0;
        e = 6400 * 2047 / (65536 << rt);
        m = 1 << ustep_res_i;
        `CHK("pulse_rate", 1'b1, n >= e - 1 && n <= e + 2)
        `CHK("ustep_pos", p0 - 32'(n), p1)
        `CHK("fullsteps", 1'b1, (fulls - f0) * m >= n - m && (fulls - f0) * m <= n + m)
        @(negedge clk_sys_i);
    endtask
    task automatic finish_test;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #3000000;
        miscompares++;
        finish_test();
    end
    initial begin
        void'($urandom(32'he91e));
        repeat (20) @(negedge clk_sys_i);
        sys_rst_i = 0;
        for (int i = 0; i < 32; i++) accel_case(1'($urandom), 4'(i), 4'(i * 7), 11'($urandom));
        accel_case(1, 4'h0, 4'hd, 11'h0);
        accel_case(1, 4'hd, 4'h0, 11'h7ff);
        $display("test accel done");
        for (int i = 0; i < 12; i++) enc_pulse(1'($urandom), 1'($urandom));
        $display("test encoder done");
        @(negedge clk_sys_i);
        reverse_shaft_i = 0;
        positioning_move_i = 0;
        ramp_shift_i = 0;
        accel_i = 11'h7ff;
        ustep_res_i = 4'($urandom % 9);
        vel_target_i = 12'sh800;
        n = 0;
        while (vel_now_o !== -12'sd2047 && n < 30000) begin
            @(negedge clk_sys_i);
            n++;
        end
        `CHK("vel_now", -12'sd2047, vel_now_o)
        rate_win(4'h0);
        rate_win(4'h2);
        `CHK("dir", 1'b1, last_dir)
        reverse_shaft_i = 1;
        repeat (800) @(negedge clk_sys_i);
        `CHK("dir_rev", 1'b0, last_dir)
        $display("test motion done");
        ext_step_mode_i = 1;
        repeat (2) @(negedge clk_sys_i);
        // a running ramp would now pull toward zero
        vel_target_i = 12'sh000;
        s0 = steps;
        repeat (3) begin
            repeat (6) @(negedge clk_sys_i);
            ext_step_i = ~ext_step_i;
            repeat (6) @(negedge clk_sys_i);
            ext_step_i = ~ext_step_i;
        end
        repeat (10) @(negedge clk_sys_i);
        `CHK("ext_steps", 3, steps - s0)
        `CHK("ext_dir", 1'b0, last_dir)
        `CHK("vel_held", -12'sd2047, vel_now_o)
        $display("test external done");
        finish_test();
    end
endmodule
bind step_rate_ramp_scaler step_rate_ramp_scaler_chk step_rate_ramp_scaler_chk_i (.*);
